// File: design/ebbl_pkg.sv
// package for the external bus busy, lock and clock block
// assumes one core clock domain and one link clock equal to the core clock out
//
// Notes on behaviour
// - busy moves only on link clock edges
// - take bus only after busy released
// - owner may park with busy held
// - release busy by driving high, then float
// - lock from read start to write end
// - no external access keeps lock deasserted
// - only bit-set, clear, bit-change lock automatically
// - lock-hold bit forces lock asserted
// - column strobe driven while owning bus
// - column strobe floats unless owner or enabled
// - bus clock runs only when owner and enabled
// - bus clock leads core clock quarter period; the lead is left to the clock pll
// - inverted bus clock while owner, else floats
// - request while bus needed, or hold bit
// - grant withdrawn: release after current cycle
// - reset drops request, returns to non-owner
package ebbl_pkg;

  // link clock cycles in one external bus cycle
  localparam int CYCLE_LEN = 2;
  localparam logic LOCK_N_RESET = 1'h1;
  localparam logic REQ_N_RESET = 1'h1;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW = 2'h2
  } ebbl_op_t;

  typedef enum logic [1:0] {
    INS_OTHER = 2'h0,
    INS_BIT_SET = 2'h1,
    INS_CLEAR = 2'h2,
    INS_BIT_CHANGE = 2'h3
  } ebbl_instr_t;

  typedef struct packed {
    logic external;
    ebbl_op_t op;
    ebbl_instr_t instr;
  } ebbl_cmd_t;

  typedef struct packed {
    logic lock_hold_bit;
    logic request_hold_bit;
    logic mastership_enable_bit;
    logic bus_clock_enable_bit;
  } ebbl_ctl_t;

  localparam ebbl_ctl_t CTL_RESET = 4'h0;
  localparam ebbl_cmd_t CMD_RESET = 5'h00;

  // gray along idle, wait, own, access, read, write, release
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_OWN = 3'h3,
    ST_ACCESS = 3'h2,
    ST_READ = 3'h6,
    ST_WRITE = 3'h7,
    ST_RELEASE = 3'h5
  } ebbl_state_t;

endpackage

// File: design/ebbl_top.sv
// bus busy handshake, bus lock, column strobe and bus clock outputs
// assumes core commands on clock_i and bus pins synchronous to link_clk_i
`timescale 1ns/1ps
`default_nettype none
module ebbl_top #(
  parameter int CYCLE_LEN = ebbl_pkg::CYCLE_LEN
) (
  // core domain
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire ebbl_pkg::ebbl_cmd_t cmd_i,
  input wire ebbl_pkg::ebbl_ctl_t ctl_i,
  output logic cmd_ready_o,
  output logic cmd_done_o,
  output logic owner_o,
  // link domain
  input wire logic link_clk_i,
  input wire logic bus_grant_n_i,
  input wire logic bus_busy_n_i,
  output logic bus_busy_n_o,
  output logic bus_busy_oe_o,
  output logic bus_request_n_o,
  output logic bus_lock_n_o,
  output logic cas_n_o,
  output logic cas_oe_o,
  output logic bclk_o,
  output logic bclk_oe_o,
  output logic bclk_n_o,
  output logic bclk_n_oe_o
);

  localparam int CW = $clog2(CYCLE_LEN) + 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLE_LEN - 1);

  if (CYCLE_LEN < 1) begin : g_bad_len
    $error("CYCLE_LEN must be at least 1");
  end

  function automatic logic lock_eligible(input ebbl_pkg::ebbl_cmd_t c);
    lock_eligible = c.external && (c.op == ebbl_pkg::OP_RMW) &&
                    (c.instr != ebbl_pkg::INS_OTHER);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // core domain: command accept and toggle handshake

  logic busy;
  logic req_tgl;
  logic done;
  ebbl_pkg::ebbl_cmd_t cmd_hold;
  logic ack_s1, ack_s2, ack_s3;
  logic own_s1, own_s2;
  logic ack_tgl;
  logic owner;

  wire accept = cmd_valid_i && !busy;
  wire internal_only = accept && !cmd_i.external;
  wire ack_evt = ack_s2 ^ ack_s3;

  assign cmd_ready_o = !busy;
  assign cmd_done_o = done;
  assign owner_o = own_s2;

  // internal accesses never touch the bus and so never lock it
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy <= 1'b0;
      req_tgl <= 1'b0;
      done <= 1'b0;
      cmd_hold <= ebbl_pkg::CMD_RESET;
    end else begin
      done <= internal_only || ack_evt;
      if (accept && cmd_i.external) begin
        busy <= 1'b1;
        req_tgl <= ~req_tgl;
        cmd_hold <= cmd_i;
      end else if (ack_evt) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      own_s1 <= 1'b0;
      own_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      own_s1 <= owner;
      own_s2 <= own_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: synchronisers

  logic rst_s1, lrst;
  logic req_s1, req_s2, req_s3;
  logic gnt_s1, gnt_s2;
  logic bb_s1, bb_s2;
  ebbl_pkg::ebbl_ctl_t ctl_s1, ctl_l;

  // reset reaches the link side two link edges late; hold srst_i long enough
  always_ff @(posedge link_clk_i) begin
    rst_s1 <= srst_i;
    lrst <= rst_s1;
  end

  // grant and busy are already link synchronous; two stages cost latency only
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      gnt_s1 <= 1'b1;
      gnt_s2 <= 1'b1;
      bb_s1 <= 1'b0;
      bb_s2 <= 1'b0;
      ctl_s1 <= ebbl_pkg::CTL_RESET;
      ctl_l <= ebbl_pkg::CTL_RESET;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      gnt_s1 <= bus_grant_n_i;
      gnt_s2 <= gnt_s1;
      bb_s1 <= bus_busy_n_i;
      bb_s2 <= bb_s1;
      ctl_s1 <= ctl_i;
      ctl_l <= ctl_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: arbitration and cycle sequencer

  ebbl_pkg::ebbl_state_t state, next_state;
  ebbl_pkg::ebbl_cmd_t cmd_l;
  logic [CW-1:0] cnt;
  logic pend;
  logic wr_pend;
  logic lock_act;
  logic rmw_lock;

  wire granted = !gnt_s2;
  wire bus_free = bb_s2;
  wire want = pend || ctl_l.request_hold_bit;
  wire new_cmd = req_s2 ^ req_s3;
  wire last = (cnt == CNT_LAST);
  wire in_cycle = (state == ebbl_pkg::ST_ACCESS) || (state == ebbl_pkg::ST_READ) ||
                  (state == ebbl_pkg::ST_WRITE);
  wire cmd_end = last && ((state == ebbl_pkg::ST_ACCESS) ||
                          (state == ebbl_pkg::ST_WRITE));
  wire write_end = last && (state == ebbl_pkg::ST_WRITE);
  wire read_end = last && (state == ebbl_pkg::ST_READ);
  wire is_rmw = (cmd_l.op == ebbl_pkg::OP_RMW);
  wire start_read = (next_state == ebbl_pkg::ST_READ) && (state != ebbl_pkg::ST_READ);
  // an rmw lock is kept apart from the hold bit, so clearing the bit frees the line
  wire next_rmw_lock = (rmw_lock && !write_end) ||
                       (start_read && lock_eligible(cmd_l));
  wire next_lock = ctl_l.lock_hold_bit || next_rmw_lock;

  assign owner = (state != ebbl_pkg::ST_IDLE) && (state != ebbl_pkg::ST_WAIT);

  always_comb begin
    next_state = state;
    case (state)
      ebbl_pkg::ST_IDLE: begin
        if (want) begin
          next_state = ebbl_pkg::ST_WAIT;
        end
      end
      ebbl_pkg::ST_WAIT: begin
        if (!want) begin
          next_state = ebbl_pkg::ST_IDLE;
        end else if (granted && bus_free) begin
          next_state = ebbl_pkg::ST_OWN;
        end
      end
      ebbl_pkg::ST_OWN: begin
        if (!granted) begin
          next_state = ebbl_pkg::ST_RELEASE;
        end else if (pend && is_rmw) begin
          next_state = wr_pend ? ebbl_pkg::ST_WRITE : ebbl_pkg::ST_READ;
        end else if (pend) begin
          next_state = ebbl_pkg::ST_ACCESS;
        end
      end
      ebbl_pkg::ST_ACCESS: begin
        if (last) begin
          next_state = ebbl_pkg::ST_OWN;
        end
      end
      ebbl_pkg::ST_READ: begin
        if (last) begin
          next_state = granted ? ebbl_pkg::ST_WRITE : ebbl_pkg::ST_RELEASE;
        end
      end
      ebbl_pkg::ST_WRITE: begin
        if (last) begin
          next_state = ebbl_pkg::ST_OWN;
        end
      end
      ebbl_pkg::ST_RELEASE: begin
        next_state = ebbl_pkg::ST_IDLE;
      end
      default: begin
        next_state = ebbl_pkg::ST_IDLE;
      end
    endcase
  end

  // with grant held and no command pending, own simply stays put: the bus is parked
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      state <= ebbl_pkg::ST_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= (in_cycle && !last) ? cnt + CW'(1) : '0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      pend <= 1'b0;
      wr_pend <= 1'b0;
      ack_tgl <= 1'b0;
      cmd_l <= ebbl_pkg::CMD_RESET;
      lock_act <= 1'b0;
      rmw_lock <= 1'b0;
    end else begin
      lock_act <= next_lock;
      rmw_lock <= next_rmw_lock;
      if (new_cmd) begin
        pend <= 1'b1;
        cmd_l <= cmd_hold;
      end else if (cmd_end) begin
        pend <= 1'b0;
        ack_tgl <= ~ack_tgl;
      end
      if (read_end) begin
        wr_pend <= 1'b1;
      end else if (write_end) begin
        wr_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: pins

  logic bclk_gate;

  // all pin drivers change on link edges only
  assign bus_busy_oe_o = owner;
  assign bus_busy_n_o = (state == ebbl_pkg::ST_RELEASE);
  assign bus_request_n_o = lrst ? ebbl_pkg::REQ_N_RESET : !want;
  assign bus_lock_n_o = lrst ? ebbl_pkg::LOCK_N_RESET : !lock_act;
  assign cas_n_o = !(in_cycle && (cnt != '0));
  assign cas_oe_o = owner || ctl_l.mastership_enable_bit;

  // gate changes on the falling edge so the gated clock never glitches;
  // the quarter period lead over the core clock is left to the clock pll
  always_ff @(negedge link_clk_i) begin
    if (lrst) begin
      bclk_gate <= 1'b0;
    end else begin
      bclk_gate <= owner && ctl_l.bus_clock_enable_bit;
    end
  end

  assign bclk_o = link_clk_i && bclk_gate;
  assign bclk_oe_o = bclk_gate;
  assign bclk_n_o = !bclk_o;
  assign bclk_n_oe_o = owner;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_take_free_bus: assert property (@(posedge link_clk_i) disable iff (lrst)
    $rose(bus_busy_oe_o) |-> $past(bb_s2) && $past(granted))
    else $error("bus taken while busy held");

  a_release_high: assert property (@(posedge link_clk_i) disable iff (lrst)
    $fell(bus_busy_oe_o) |-> $past(bus_busy_n_o) && !$past(bus_busy_n_o, 2))
    else $error("busy released without high drive");

  a_park_hold: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state == ebbl_pkg::ST_OWN) && granted && !pend && !new_cmd
      |=> bus_busy_oe_o && !bus_busy_n_o)
    else $error("parked owner dropped busy");

  a_lock_read: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state == ebbl_pkg::ST_READ) && (cnt == '0) && lock_eligible(cmd_l)
      |-> !bus_lock_n_o)
    else $error("lock missing at read start");

  a_lock_end: assert property (@(posedge link_clk_i) disable iff (lrst)
    write_end && !ctl_l.lock_hold_bit ##1 !ctl_l.lock_hold_bit |-> bus_lock_n_o)
    else $error("lock held past write end");

  a_lock_cause: assert property (@(posedge link_clk_i) disable iff (lrst)
    $fell(bus_lock_n_o) |-> $past(ctl_l.lock_hold_bit) ||
      ((state == ebbl_pkg::ST_READ) && lock_eligible(cmd_l)))
    else $error("lock asserted by wrong cause");

  a_cas_float: assert property (@(posedge link_clk_i) disable iff (lrst)
    !owner && !ctl_l.mastership_enable_bit |-> !cas_oe_o && cas_n_o)
    else $error("column strobe driven while not owner");

  // the gate is refreshed on the falling edge, so at a rising edge it mirrors the enable
  a_bclk_gate: assert property (@(posedge link_clk_i) disable iff (lrst)
    !(owner && ctl_l.bus_clock_enable_bit) |-> !bclk_oe_o)
    else $error("bus clock enabled without ownership");

  a_grant_loss: assert property (@(posedge link_clk_i) disable iff (lrst)
    (state == ebbl_pkg::ST_OWN) && !granted |=> bus_busy_n_o ##1 !bus_busy_oe_o)
    else $error("grant loss not followed by release");

  a_request_level: assert property (@(posedge link_clk_i) disable iff (lrst)
    pend |-> !bus_request_n_o)
    else $error("request not asserted while pending");

  a_lock_hold: assert property (@(posedge link_clk_i) disable iff (lrst)
    ctl_l.lock_hold_bit |=> !bus_lock_n_o)
    else $error("lock hold bit not obeyed");

  a_lock_quiet: assert property (@(posedge link_clk_i) disable iff (lrst)
    !ctl_l.lock_hold_bit && !rmw_lock && !start_read |=> bus_lock_n_o)
    else $error("lock asserted with no locked access");

  a_cas_owner: assert property (@(posedge link_clk_i) disable iff (lrst)
    !cas_n_o |-> bus_busy_oe_o && !bus_busy_n_o)
    else $error("column strobe outside own cycle");

  a_reset_lock: assert property (@(posedge link_clk_i)
    lrst |-> bus_lock_n_o)
    else $error("lock asserted in reset");

  a_reset_request: assert property (@(posedge link_clk_i)
    lrst |-> bus_request_n_o)
    else $error("request asserted in reset");

endmodule
`default_nettype wire

// File: testbench/ebbl_arb_model.sv
// partner: bus arbiter, pulled-up busy wire and one other bus master
// assumes the far side moves only on the link clock rising edge
`timescale 1ns/1ps
`default_nettype none
module ebbl_arb_model (
  // bench controls
  input wire logic link_clk_i,
  input wire logic grant_en_i,
  input wire logic other_busy_i,
  // device pins
  input wire logic bus_request_n_i,
  input wire logic bus_busy_n_i,
  input wire logic bus_busy_oe_i,
  input wire logic bus_lock_n_i,
  // resolved lines
  output logic bus_grant_n_o,
  output logic bus_busy_wire_o,
  output logic mem_reserved_o
);
  logic other_drv = 1'h0;
  initial bus_grant_n_o = 1'h1;
  ////////////////////////////////////////////////////////////////
  // grant kept while parked, so the owner reuses the bus unasked
  always @(posedge link_clk_i) begin
    bus_grant_n_o <= !(grant_en_i && (!bus_request_n_i || !bus_grant_n_o));
    other_drv <= other_busy_i;
  end
  // pull-up wins once every driver has let go
  assign bus_busy_wire_o = !((bus_busy_oe_i && !bus_busy_n_i) || other_drv);
  assign mem_reserved_o = !bus_lock_n_i;
endmodule
`default_nettype wire

// File: testbench/ebbl_top_tb.sv
// bench for the bus busy, lock and bus clock block
// assumes the arbiter model beside it; inputs change on falling clock_i
`timescale 1ns/1ps
`default_nettype none
module ebbl_top_tb;
  logic clock_i = 1'h0;
  logic link_clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic cmd_valid_i = 1'h0;
  ebbl_pkg::ebbl_cmd_t cmd_i = ebbl_pkg::CMD_RESET;
  ebbl_pkg::ebbl_ctl_t ctl_i = ebbl_pkg::CTL_RESET;
  logic grant_en = 1'h0;
  logic other_busy = 1'h0;
  logic cmd_ready_o, cmd_done_o, owner_o, grant_n, busy_wire, busy_n, busy_oe, req_n;
  logic lock_n, cas_n, cas_oe, bclk, bclk_oe, bclk_n, bclk_n_oe, lk, b, cs, mem_res;
  int num_errors = 0;
  int n_checks = 0;
  int n_cycles = 0;
  int cyc;
  int i;

  always #20 clock_i = ~clock_i;
  // odd start keeps the two clocks apart in phase
  initial begin
    #7;
    forever #24 link_clk_i = ~link_clk_i;
  end

  ebbl_top dut (.clock_i(clock_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .ctl_i(ctl_i), .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
    .owner_o(owner_o), .link_clk_i(link_clk_i), .bus_grant_n_i(grant_n),
    .bus_busy_n_i(busy_wire), .bus_busy_n_o(busy_n), .bus_busy_oe_o(busy_oe),
    .bus_request_n_o(req_n), .bus_lock_n_o(lock_n), .cas_n_o(cas_n), .cas_oe_o(cas_oe),
    .bclk_o(bclk), .bclk_oe_o(bclk_oe), .bclk_n_o(bclk_n), .bclk_n_oe_o(bclk_n_oe));

  ebbl_arb_model arb (.link_clk_i(link_clk_i), .grant_en_i(grant_en),
    .other_busy_i(other_busy), .bus_request_n_i(req_n), .bus_busy_n_i(busy_n),
    .bus_busy_oe_i(busy_oe), .bus_lock_n_i(lock_n), .bus_grant_n_o(grant_n),
    .bus_busy_wire_o(busy_wire), .mem_reserved_o(mem_res));

  ////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    n_cycles++;
    if (n_cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task chk(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task offer(input logic ext, input ebbl_pkg::ebbl_op_t op, input ebbl_pkg::ebbl_instr_t ins);
    @(negedge clock_i);
    while (cmd_ready_o !== 1'h1) @(negedge clock_i);
    cmd_valid_i = 1'h1;
    cmd_i = '{ext, op, ins};
    @(negedge clock_i);
    cmd_valid_i = 1'h0;
  endtask

  // lock is sampled at every core cycle while the command runs
  task finish;
    lk = 1'h0;
    cs = 1'h0;
    cyc = 1;
    while (cmd_done_o !== 1'h1) begin
      if (lock_n === 1'h0) lk = 1'h1;
      if (cas_n === 1'h0) cs = 1'h1;
      @(negedge clock_i);
      cyc++;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  task t_reset;
    chk(req_n, 1'h1, "request");
    chk(owner_o, 1'h0, "owner");
    chk(lock_n, 1'h1, "lock");
    chk(busy_oe, 1'h0, "busy drive");
    chk(cas_oe, 1'h0, "cas drive");
    chk(bclk_oe, 1'h0, "bclk drive");
    chk(bclk_n_oe, 1'h0, "bclk_n drive");
  endtask

  task t_internal;
    offer(1'h0, ebbl_pkg::OP_RMW, ebbl_pkg::INS_CLEAR);
    finish();
    chk(cyc == 1, 1'h1, "internal done");
    chk(lk, 1'h0, "lock internal");
    chk(req_n, 1'h1, "request internal");
  endtask

  task t_park;
    grant_en = 1'h1;
    other_busy = 1'h1;
    offer(1'h1, ebbl_pkg::OP_RMW, ebbl_pkg::INS_BIT_SET);
    repeat (30) @(negedge clock_i);
    chk(req_n, 1'h0, "request waiting");
    chk(owner_o, 1'h0, "owner while busy");
    chk(busy_oe, 1'h0, "busy drive waiting");
    other_busy = 1'h0;
    finish();
    chk(lk, 1'h1, "lock rmw");
    chk(cs, 1'h1, "cas strobe rmw");
    repeat (4) @(negedge clock_i);
    chk(lock_n, 1'h1, "lock after write");
    chk(owner_o, 1'h1, "owner");
    chk(busy_oe & ~busy_n, 1'h1, "parked busy");
    chk(req_n, 1'h1, "request idle");
    chk(cas_oe, 1'h1, "cas owner");
  endtask

  task t_instr;
    for (i = 0; i < 4; i++) begin
      offer(1'h1, ebbl_pkg::OP_RMW, ebbl_pkg::ebbl_instr_t'(i[1:0]));
      finish();
      chk(lk, i != 0, "lock by instr");
    end
    offer(1'h1, ebbl_pkg::OP_WRITE, ebbl_pkg::INS_BIT_CHANGE);
    finish();
    chk(lk, 1'h0, "lock plain write");
    chk(cs, 1'h1, "cas strobe write");
  endtask

  task t_hold;
    ctl_i.lock_hold_bit = 1'h1;
    repeat (10) @(negedge clock_i);
    chk(lock_n, 1'h0, "hold lock");
    chk(mem_res, 1'h1, "memory reserved");
    ctl_i.lock_hold_bit = 1'h0;
    offer(1'h1, ebbl_pkg::OP_READ, ebbl_pkg::INS_OTHER);
    finish();
    repeat (4) @(negedge clock_i);
    chk(lock_n, 1'h1, "lock after hold");
  endtask

  task t_bclk;
    ctl_i.bus_clock_enable_bit = 1'h1;
    repeat (10) @(negedge clock_i);
    repeat (3) begin
      @(posedge link_clk_i);
      #12;
      b = bclk;
      chk(bclk_oe, 1'h1, "bclk drive");
      chk(bclk_n_oe & (bclk_n ^ bclk), 1'h1, "bclk_n");
      @(negedge link_clk_i);
      #12;
      chk(bclk, ~b, "bclk toggle");
    end
  endtask

  task t_release;
    @(negedge clock_i);
    grant_en = 1'h0;
    for (i = 0; i < 30 && !(busy_oe === 1'h1 && busy_n === 1'h1); i++) begin
      @(posedge link_clk_i);
      #1;
    end
    chk(busy_n, 1'h1, "busy driven high");
    @(posedge link_clk_i);
    #1;
    chk(busy_oe, 1'h0, "busy floats");
    repeat (10) @(negedge clock_i);
    chk(owner_o, 1'h0, "owner released");
    chk(bclk_oe, 1'h0, "bclk floats");
    chk(bclk_n_oe, 1'h0, "bclk_n floats");
    chk(cas_oe, 1'h0, "cas floats");
  endtask

  task t_cas;
    ctl_i.mastership_enable_bit = 1'h1;
    repeat (10) @(negedge clock_i);
    chk(cas_oe, 1'h1, "cas enabled");
    ctl_i.mastership_enable_bit = 1'h0;
    ctl_i.request_hold_bit = 1'h1;
    repeat (10) @(negedge clock_i);
    chk(cas_oe, 1'h0, "cas disabled");
    chk(req_n, 1'h0, "request hold");
  endtask

  ////////////////////////////////////////////////////////////////
  // reset runs longer than three cycles so the link side sees it too
  initial begin
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    srst_i = 1'h0;
    repeat (10) @(negedge clock_i);
    t_reset();
    t_internal();
    t_park();
    t_instr();
    t_hold();
    t_bclk();
    t_release();
    t_cas();
    report_and_stop();
  end
endmodule
`default_nettype wire
